// *** wdtu_pkg.sv ***
// shared constants and types for the watchdog timer unit
package wdtu_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // ****************************************************************
  // watchdog_control fields
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h7A;
  localparam int CTRL_KEEP_BIT = 7;
  localparam int PERIOD_MSB = 6;
  localparam int PERIOD_LSB = 4;
  localparam int KEY_MSB = 3;
  localparam int KEY_LSB = 0;
  localparam logic [3:0] KEY_DISABLE = 4'hA;

  // ****************************************************************
  // option register fields
  // ****************************************************************
  localparam int CFG_W = 4;
  localparam int CFG_SRC_SUB = 0;
  localparam int CFG_SUB_RC = 1;
  localparam int CFG_ENABLE = 2;
  localparam int CFG_PAIRED = 3;
  localparam logic [3:0] CFG_RESET = 4'h7;

  // ****************************************************************
  // status and interrupt fields
  // ****************************************************************
  localparam int STAT_EXPIRED = 0;
  localparam int STAT_PDOWN = 1;
  localparam int STAT_ENABLED = 2;
  localparam int STAT_CNT_LSB = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF_RUN = 0;
  localparam int IRQ_OVF_LOW = 1;

  // ****************************************************************
  // counter and bus constants
  // ****************************************************************
  localparam int CNT_W = 15;
  localparam logic [15:0] PERIOD_BASE = 16'h0100;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    REG_CTRL, REG_CFG, REG_STAT, REG_IRQ_STAT, REG_IRQ_MASK, REG_NONE
  } wdtu_reg_t;

  typedef enum logic [1:0] {PAIR_NONE, PAIR_FIRST, PAIR_SECOND} wdtu_pair_t;

  // one-cycle instruction strobes from the processor core
  typedef struct packed {
    logic single_clear_instruction;
    logic paired_clear_first;
    logic paired_clear_second;
    logic halt;
  } wdtu_instr_t;

  // power mode levels from the processor core
  typedef struct packed {
    logic sleep;
    logic idle;
  } wdtu_mode_t;

endpackage : wdtu_pkg

// *** wdtu_top.sv ***
// watchdog timer unit with its AXI4-Lite register slave
//
// What this block does
// R01 - option picks watchdog source: low-speed subclock or system clock / 4
// R02 - option picks subclock from crystal oscillator or slow RC oscillator
// R03 - period field bits 6..4: 256 source periods at 000, doubling to 32768
// R04 - control bit 7 keeps system clock running in idle when set
// R05 - disabled only if option disables and key bits 3..0 equal 1010
// R06 - control register resets to keep 0, period 111, key 1010
// R07 - software should write key 0101 when the watchdog is used
// R08 - overflow in normal run gives full device reset and sets expired flag
// R09 - overflow in sleep or idle sets expired, clears only PC and SP
// R10 - counter cleared by reset pin low, accepted clear, or halt
// R11 - option selects single clear instruction or paired clear instructions
// R12 - paired clears must alternate; repeating the same one does nothing
// R13 - while disabled, clear and halt leave the counter alone; halt still sets power-down and clears expired
// R14 - system/4 source stops counting in sleep and clock-off idle
// R15 - halt clears and restarts the counter when enabled
// R16 - power-down flag cleared by power-up or accepted clear, set by halt
// R17 - overflow in idle or sleep leaves expired and power-down both at 1
// R18 - 15-bit divider, overflow at selected tap, single-cycle pulse
`timescale 1ns/1ps
module wdtu_top (
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [wdtu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdtu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire wdtu_pkg::wdtu_instr_t core_instr,
  input wire wdtu_pkg::wdtu_mode_t core_mode,
  input wire logic external_initialise_pin_n,
  input wire logic crystal_low_speed_osc_tick,
  input wire logic internal_slow_rc_osc_tick,
  output logic device_reset,
  output logic pc_sp_clear,
  output logic wdt_overflow,
  output logic watchdog_expired_flag,
  output logic power_down_flag,
  output logic idle_system_clock_keep,
  output logic irq
);
  import wdtu_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************

  // map a byte address onto a register
  function automatic wdtu_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
    wdtu_reg_t r;
    r = REG_NONE;
    unique case (addr)
      OFF_CTRL: r = REG_CTRL;
      OFF_CFG: r = REG_CFG;
      OFF_STAT: r = REG_STAT;
      OFF_IRQ_STAT: r = REG_IRQ_STAT;
      OFF_IRQ_MASK: r = REG_IRQ_MASK;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction : reg_decode

  // last count before overflow for a period code
  function automatic logic [CNT_W-1:0] period_last(input logic [2:0] sel);
    logic [15:0] span;
    span = PERIOD_BASE << sel;
    return CNT_W'(span - 16'h0001);
  endfunction : period_last

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] ctrl_r;
  logic [CFG_W-1:0] cfg_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0] div_r;
  wdtu_pair_t pair_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  logic wdt_en;
  logic low_power;
  logic sys_run;
  logic src_tick;
  logic clr_ok;
  logic halt_ok;
  logic hit;
  logic wr_fire;
  logic rd_fire;
  wdtu_reg_t wr_reg;
  wdtu_reg_t rd_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // ****************************************************************
  // watchdog decode
  // ****************************************************************

  // enable, source selection and clear acceptance
  always_comb begin
    wdt_en = cfg_r[CFG_ENABLE] |
             (ctrl_r[KEY_MSB:KEY_LSB] != KEY_DISABLE); // R05
    low_power = core_mode.sleep | core_mode.idle;
    sys_run = ~(core_mode.sleep |
                (core_mode.idle & ~ctrl_r[CTRL_KEEP_BIT])); // R04 R14
    if (cfg_r[CFG_SRC_SUB]) begin // R01
      src_tick = cfg_r[CFG_SUB_RC] ? internal_slow_rc_osc_tick
                                   : crystal_low_speed_osc_tick; // R02
    end else begin
      src_tick = sys_run & (div_r == DIV4_LAST); // R01 R14
    end
    if (cfg_r[CFG_PAIRED]) begin // R11
      clr_ok = wdt_en &
               ((core_instr.paired_clear_first & (pair_r != PAIR_FIRST)) |
                (core_instr.paired_clear_second &
                 (pair_r != PAIR_SECOND))); // R12 R13
    end else begin
      clr_ok = wdt_en & core_instr.single_clear_instruction; // R11 R13
    end
    halt_ok = wdt_en & core_instr.halt; // R15
    hit = wdt_en & external_initialise_pin_n & src_tick &
          (cnt_r == period_last(ctrl_r[PERIOD_MSB:PERIOD_LSB])); // R03 R18
  end

  // ****************************************************************
  // counter
  // ****************************************************************

  // system clock divide by four, halted with the instruction clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 2'h0;
    end else if (sys_run) begin // R14
      div_r <= div_r + 2'h1;
    end
  end

  // binary divider with clears
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (!external_initialise_pin_n || !wdt_en) begin // R10
      cnt_r <= '0;
    end else if (clr_ok || halt_ok || hit) begin // R10 R15 R18
      cnt_r <= '0;
    end else if (src_tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // remembers which paired clear was accepted last
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pair_r <= PAIR_NONE;
    end else if (!external_initialise_pin_n || !wdt_en ||
                 !cfg_r[CFG_PAIRED]) begin
      pair_r <= PAIR_NONE;
    end else if (clr_ok) begin
      unique case (pair_r)
        PAIR_NONE: pair_r <= core_instr.paired_clear_first ? PAIR_FIRST
                                                           : PAIR_SECOND;
        PAIR_FIRST: pair_r <= PAIR_SECOND; // R12
        PAIR_SECOND: pair_r <= PAIR_FIRST; // R12
      endcase
    end
  end

  // ****************************************************************
  // overflow actions and flags
  // ****************************************************************

  // overflow pulses, one cycle each
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_overflow <= 1'b0;
      device_reset <= 1'b0;
      pc_sp_clear <= 1'b0;
    end else begin
      wdt_overflow <= hit; // R18
      device_reset <= hit & ~low_power; // R08
      pc_sp_clear <= hit & low_power; // R09
    end
  end

  // expired flag: overflow sets, clear or halt drops it, set wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_expired_flag <= 1'b0;
    end else if (hit) begin // R08 R09 R17
      watchdog_expired_flag <= 1'b1;
    end else if (clr_ok || core_instr.halt) begin
      watchdog_expired_flag <= 1'b0;
    end
  end

  // power-down flag: halt sets, accepted clear drops it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_down_flag <= 1'b0; // R16
    end else if (core_instr.halt) begin // R16
      power_down_flag <= 1'b1;
    end else if (clr_ok) begin // R16
      power_down_flag <= 1'b0;
    end
  end // overflow never touches it, so low-power overflow keeps it at 1 R17

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_reg = reg_decode(awaddr_r);

  // address and data taken in either order, response after both
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software-written registers, low byte lane only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET; // R06
      cfg_r <= CFG_RESET;
      irq_mask_r <= '0;
    end else if (wr_fire && wstrb_r[0]) begin
      unique case (wr_reg)
        REG_CTRL: ctrl_r <= wdata_r[7:0]; // R07 key 0101 advised
        REG_CFG: cfg_r <= wdata_r[CFG_W-1:0];
        REG_IRQ_MASK: irq_mask_r <= wdata_r[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign idle_system_clock_keep = ctrl_r[CTRL_KEEP_BIT]; // R04

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_reg = reg_decode(s_axi_araddr);

  // one read at a time, data answered on the cycle after the address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (rd_reg)
        REG_CTRL: s_axi_rdata[7:0] <= ctrl_r;
        REG_CFG: s_axi_rdata[CFG_W-1:0] <= cfg_r;
        REG_STAT: begin
          s_axi_rdata[STAT_EXPIRED] <= watchdog_expired_flag;
          s_axi_rdata[STAT_PDOWN] <= power_down_flag;
          s_axi_rdata[STAT_ENABLED] <= wdt_en;
          s_axi_rdata[STAT_CNT_LSB +: CNT_W] <= cnt_r;
        end
        REG_IRQ_STAT: s_axi_rdata[IRQ_W-1:0] <= irq_stat_r;
        REG_IRQ_MASK: s_axi_rdata[IRQ_W-1:0] <= irq_mask_r;
        default: ;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set = {hit & low_power, hit & ~low_power};
  assign irq_clr = (rd_fire && rd_reg == REG_IRQ_STAT) ? '1 : '0;

  // sticky events, cleared by reading, a new event wins over the clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule : wdtu_top

// *** wdtu_properties.sv ***
// concurrent checks on the watchdog timer unit ports
`timescale 1ns/1ps
module wdtu_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire wdtu_pkg::wdtu_instr_t core_instr,
  input wire wdtu_pkg::wdtu_mode_t core_mode,
  input wire logic external_initialise_pin_n,
  input wire logic device_reset,
  input wire logic pc_sp_clear,
  input wire logic wdt_overflow,
  input wire logic watchdog_expired_flag,
  input wire logic power_down_flag
);
  import wdtu_pkg::*;
  // ****************
  // overflow and halt checks
  // ****************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  ovf_one_cycle_a: assert property (wdt_overflow |=> !wdt_overflow)
    else $error("overflow pulse lasts more than one cycle");
  run_reset_kind_a: assert property (device_reset |-> wdt_overflow &&
    !$past(core_mode.sleep || core_mode.idle))
    else $error("device reset without overflow in normal run");
  low_reset_kind_a: assert property (pc_sp_clear |-> wdt_overflow &&
    $past(core_mode.sleep || core_mode.idle))
    else $error("pc and sp clear without overflow in sleep or idle");
  one_action_a: assert property (wdt_overflow |->
    device_reset ^ pc_sp_clear)
    else $error("overflow must give exactly one reset kind");
  expired_set_a: assert property (wdt_overflow |-> watchdog_expired_flag)
    else $error("expired flag not set on overflow");
  low_flags_a: assert property (pc_sp_clear |-> watchdog_expired_flag &&
    power_down_flag)
    else $error("flags not both set after overflow in sleep or idle");
  halt_pdown_a: assert property (core_instr.halt |=> power_down_flag)
    else $error("halt did not set power-down flag");
  pin_clear_a: assert property (!external_initialise_pin_n |->
    ##2 !wdt_overflow [*8])
    else $error("overflow too soon after reset pin clear");
endmodule : wdtu_properties

bind wdtu_top wdtu_properties wdtu_properties_i (
  .sys_clk(sys_clk), .rstn(rstn), .core_instr(core_instr),
  .core_mode(core_mode),
  .external_initialise_pin_n(external_initialise_pin_n),
  .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
  .wdt_overflow(wdt_overflow),
  .watchdog_expired_flag(watchdog_expired_flag),
  .power_down_flag(power_down_flag)
);

// *** wdtu_core_model.sv ***
// processor core model issuing watchdog clear and halt instructions
`timescale 1ns/1ps
module wdtu_core_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [2:0] op,
  output wdtu_pkg::wdtu_instr_t core_instr
);
  import wdtu_pkg::*;
  // one-cycle strobe, one instruction at a time
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core_instr <= '0;
    end else begin
      core_instr <= '0;
      if (go) begin
        case (op)
          3'h1: core_instr.single_clear_instruction <= 1'b1;
          3'h2: core_instr.paired_clear_first <= 1'b1;
          3'h3: core_instr.paired_clear_second <= 1'b1;
          3'h4: core_instr.halt <= 1'b1;
          default: core_instr <= '0;
        endcase
      end
    end
  end
endmodule : wdtu_core_model

// *** watchdog_timer_unit_tb.sv ***
// self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
  import wdtu_pkg::*;
  typedef struct packed {
    logic [3:0] cfg;
    logic [7:0] ctrl;
    logic [2:0] op;
    logic [1:0] md;
    logic [15:0] cyc;
  } wdtu_row_t;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, go;
  logic external_initialise_pin_n, crystal_low_speed_osc_tick;
  logic internal_slow_rc_osc_tick, device_reset, pc_sp_clear;
  logic wdt_overflow, watchdog_expired_flag, power_down_flag;
  logic idle_system_clock_keep, irq;
  logic [2:0] op;
  wdtu_instr_t core_instr;
  wdtu_mode_t core_mode;
  int err_count = 0;
  int n_compared = 0;
  int n, e;
  // cfg, ctrl, op, mode, cycles to overflow
  wdtu_row_t rows [7] = '{
    '{4'h5, 8'h05, 3'h1, 2'h0, 16'h0100},
    '{4'h7, 8'h05, 3'h1, 2'h0, 16'h0200},
    '{4'h4, 8'h05, 3'h1, 2'h0, 16'h0400},
    '{4'h5, 8'h35, 3'h1, 2'h0, 16'h0800},
    '{4'h5, 8'h75, 3'h1, 2'h0, 16'h8000},
    '{4'h5, 8'h05, 3'h4, 2'h2, 16'h0100},
    '{4'h4, 8'h85, 3'h4, 2'h1, 16'h0400}
  };
  wdtu_top wdtu_top_i (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .core_instr(core_instr),
    .core_mode(core_mode),
    .external_initialise_pin_n(external_initialise_pin_n),
    .crystal_low_speed_osc_tick(crystal_low_speed_osc_tick),
    .internal_slow_rc_osc_tick(internal_slow_rc_osc_tick),
    .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
    .wdt_overflow(wdt_overflow),
    .watchdog_expired_flag(watchdog_expired_flag),
    .power_down_flag(power_down_flag),
    .idle_system_clock_keep(idle_system_clock_keep), .irq(irq));
  wdtu_core_model wdtu_core_model_i (.sys_clk(sys_clk), .rstn(rstn),
    .go(go), .op(op), .core_instr(core_instr));
  // ****************
  // clock and ticks
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    internal_slow_rc_osc_tick <= ~internal_slow_rc_osc_tick;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  // op 5 pulses the external pin instead of the core
  task automatic issue(input logic [2:0] o, input logic [1:0] m);
    @(posedge sys_clk);
    op <= o;
    go <= (o != 3'h5);
    external_initialise_pin_n <= (o != 3'h5);
    @(posedge sys_clk);
    go <= 1'b0;
    external_initialise_pin_n <= 1'b1;
    core_mode <= m;
  endtask : issue
  task automatic wait_ovf(input int lim);
    n = 0;
    while (wdt_overflow !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_ovf
  task automatic clr_then(input logic [2:0] a, b, input int x);
    issue(a, 2'h0);
    repeat (200) @(posedge sys_clk);
    issue(b, 2'h0);
    wait_ovf(400);
    chk("clear cycles", (n > x - 5 && n < x + 5) ? x : n, x);
  endtask : clr_then
  task automatic conclude();
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // ****************
  // main sequence
  // ****************
  initial begin
    rstn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, go} = '0;
    {s_axi_arvalid, s_axi_rready, op, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    core_mode = '0;
    external_initialise_pin_n = 1'b1;
    crystal_low_speed_osc_tick = 1'b1;
    internal_slow_rc_osc_tick = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    wr(OFF_IRQ_MASK, 32'h1);
    foreach (rows[i]) begin
      wr(OFF_CFG, {28'h0, rows[i].cfg});
      wr(OFF_CTRL, {24'h0, rows[i].ctrl});
      issue(rows[i].op, rows[i].md);
      wait_ovf(40000);
      e = rows[i].cyc;
      chk("ovf cycles", (n > e - 5 && n < e + 5) ? e : n, e);
      chk("ovf kind", {device_reset, pc_sp_clear},
        {rows[i].md == 2'h0, rows[i].md != 2'h0});
      chk("flag pins", {power_down_flag, watchdog_expired_flag},
        {rows[i].op == 3'h4, 1'b1});
      rdr(OFF_STAT);
      chk("flags", rd[1:0], {rows[i].op == 3'h4, 1'b1});
    end
    chk("keep", idle_system_clock_keep, 1'b1);
    chk("irq", irq, 1'b1);
    rdr(OFF_IRQ_STAT);
    chk("irq stat", rd, 32'h3);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq cleared", irq, 1'b0);
    rdr(8'h14);
    chk("unmapped rd", rd, 32'h0);
    chk("unmapped rresp", rsp, RESP_SLVERR);
    wr(8'h14, 32'hFF);
    chk("unmapped wr", rsp, RESP_SLVERR);
    wr(OFF_CTRL, 32'h05);
    wr(OFF_CFG, 32'h4);
    issue(3'h4, 2'h2);
    wait_ovf(1200);
    chk("sleep hold", n, 1200);
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTRL, 32'h0A);
    issue(3'h1, 2'h0);
    wait_ovf(600);
    chk("disabled", n, 600);
    rdr(OFF_STAT);
    chk("disabled stat", rd & 32'h7FFF0007, 32'h2);
    wr(OFF_CTRL, 32'h05);
    rdr(OFF_STAT);
    chk("key enable", rd[2], 1'b1);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rdr(OFF_CTRL);
    chk("ctrl reset", rd, 32'h7A);
    chk("keep reset", idle_system_clock_keep, 1'b0);
    rdr(OFF_STAT);
    chk("reset enabled", rd[2:0], 3'h4);
    rdr(OFF_CFG);
    chk("cfg reset", rd, {28'h0, CFG_RESET});
    rdr(OFF_IRQ_MASK);
    chk("mask reset", rd, 32'h0);
    s_axi_wstrb <= 4'hE;
    wr(OFF_CTRL, 32'h55);
    s_axi_wstrb <= 4'hF;
    chk("strobe off rsp", rsp, RESP_OKAY);
    rdr(OFF_CTRL);
    chk("strobe off", rd, 32'h7A);
    wr(OFF_CFG, 32'hD);
    wr(OFF_CTRL, 32'h05);
    clr_then(3'h2, 3'h2, 54);
    clr_then(3'h3, 3'h3, 54);
    clr_then(3'h2, 3'h1, 54);
    clr_then(3'h3, 3'h2, 257);
    wr(OFF_CFG, 32'h5);
    clr_then(3'h1, 3'h2, 54);
    clr_then(3'h1, 3'h5, 256);
    conclude();
  end
  // hang guard, about 60000 cycles
  initial begin
    #3000000;
    err_count++;
    conclude();
  end
endmodule : watchdog_timer_unit_tb
